// ===== inc/pmeg_defines.svh
// Constants of the pulse-channel edge generator: widths, offsets, resets.
// Assumes inclusion by the package and the design files by bare name.
`ifndef PMEG_DEFINES_SVH
`define PMEG_DEFINES_SVH

`define PMEG_W          16
`define PMEG_NREG       18
`define PMEG_IX(o)      ((o) >> 2)

`define PMEG_OFS_CTRL   8'h00
`define PMEG_OFS_LIMIT  8'h04
`define PMEG_OFS_EV1    8'h08
`define PMEG_OFS_EV2    8'h0C
`define PMEG_OFS_EV3    8'h10
`define PMEG_OFS_EV4    8'h14
`define PMEG_OFS_CADJA  8'h18
`define PMEG_OFS_CADJB  8'h1C
`define PMEG_OFS_ADAPT  8'h20
`define PMEG_OFS_PHASE  8'h24
`define PMEG_OFS_SAMP1  8'h28
`define PMEG_OFS_SAMP2  8'h2C
`define PMEG_OFS_BLKAB  8'h30
`define PMEG_OFS_BLKAE  8'h34
`define PMEG_OFS_BLKBB  8'h38
`define PMEG_OFS_BLKBE  8'h3C
`define PMEG_OFS_DEAD1  8'h40
`define PMEG_OFS_DEAD2  8'h44
`define PMEG_OFS_STATUS 8'h48

`define PMEG_CTRL_MODE  1:0
`define PMEG_CTRL_PSRC  2
`define PMEG_CTRL_EN    3
`define PMEG_CTRL_MASK  16'h000F

`define PMEG_RST_LIMIT  16'h03E7
`define PMEG_RST_OTHER  16'h0000

`endif

// ===== inc/pmeg_pkg.sv
// Types shared by the pulse-channel edge generator modules.
// Assumes pmeg_defines.svh is on the include path.
`include "pmeg_defines.svh"

package pmeg_pkg;
	typedef enum logic [1:0] {
		MODE_MULTI     = 2'b00,
		MODE_RESONANT  = 2'b01,
		MODE_TRIANGLE  = 2'b10,
		MODE_LEADING   = 2'b11
	} pmeg_mode_e;

	typedef logic [`PMEG_W-1:0] pmeg_cnt_t;
	typedef logic signed [`PMEG_W+1:0] pmeg_wide_t;

	typedef struct packed {
		pmeg_mode_e mode;
		logic       phaseFromDuty;
		logic       enable;
		pmeg_cnt_t  limit;
		pmeg_cnt_t  ev1;
		pmeg_cnt_t  ev2;
		pmeg_cnt_t  ev3;
		pmeg_cnt_t  ev4;
		pmeg_cnt_t  cadjA;
		pmeg_cnt_t  cadjB;
		pmeg_cnt_t  adapt;
		pmeg_cnt_t  phase;
		pmeg_cnt_t  samp1;
		pmeg_cnt_t  samp2;
		pmeg_cnt_t  blkABeg;
		pmeg_cnt_t  blkAEnd;
		pmeg_cnt_t  blkBBeg;
		pmeg_cnt_t  blkBEnd;
		pmeg_cnt_t  dead1;
		pmeg_cnt_t  dead2;
	} pmeg_cfg_s;

	typedef struct packed {
		pmeg_cnt_t  cnt;
		pmeg_mode_e mode;
		logic       outA;
		logic       outB;
	} pmeg_stat_s;

	typedef struct packed {
		pmeg_cnt_t aRise;
		pmeg_cnt_t aFall;
		pmeg_cnt_t bRise;
		pmeg_cnt_t bFall;
		pmeg_cnt_t trigA;
		pmeg_cnt_t trigB;
		logic      aEn;
		logic      trigEn;
		logic      bFull;
	} pmeg_tgt_s;

	typedef struct packed {
		logic [`PMEG_NREG-1:0][15:0] file;
		logic                        pready;
		logic                        pslverr;
		logic [31:0]                 prdata;
	} pmeg_regs_s;

	typedef struct packed {
		pmeg_cnt_t  cnt;
		pmeg_cnt_t  lim;
		pmeg_mode_e mode;
		logic       outA;
		logic       outB;
		logic       trigA;
		logic       trigB;
		logic       phase;
		logic       samp1;
		logic       samp2;
		logic       blkA;
		logic       blkB;
	} pmeg_top_s;
endpackage

// ===== inc/pmeg_if.sv
// Carriers between the register file, the edge calculator and the core.
// Assumes pmeg_pkg is compiled first.
`timescale 1ns/10ps

interface pmeg_cfg_if;
	pmeg_pkg::pmeg_cfg_s  cfg;
	pmeg_pkg::pmeg_stat_s stat;
	modport regs (output cfg, input stat);
	modport core (input cfg, output stat);
	modport view (input cfg);
endinterface

interface pmeg_edge_if;
	pmeg_pkg::pmeg_mode_e mode;
	pmeg_pkg::pmeg_cnt_t  lim;
	pmeg_pkg::pmeg_cnt_t  duty;
	pmeg_pkg::pmeg_tgt_s  tgt;
	modport calc (input mode, lim, duty, output tgt);
	modport core (output mode, lim, duty, input tgt);
endinterface

// ===== hdl/pmeg_apb_regs.sv
// APB slave holding the channel configuration and showing its status.
// Assumes an APB master; every access gets one wait state.
`timescale 1ns/10ps
`include "pmeg_defines.svh"

module pmeg_apb_regs (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Configuration and status
	pmeg_cfg_if.regs         cfgIf
);
	pmeg_pkg::pmeg_regs_s st_reg;
	pmeg_pkg::pmeg_regs_s st_next;
	logic [5:0]           idx;
	logic [31:0]          rd;

	assign idx = paddr[7:2];

	always_comb begin
		rd = 32'h0000_0000;
		if (idx == 6'(`PMEG_IX(`PMEG_OFS_STATUS))) begin
			rd = {12'h000, cfgIf.stat.outB, cfgIf.stat.outA,
				cfgIf.stat.mode, cfgIf.stat.cnt};
		end else if (idx < 6'(`PMEG_NREG)) begin
			rd = {16'h0000, st_reg.file[idx[4:0]]};
		end
		st_next = st_reg;
		st_next.pready = 1'b0;
		if (psel && penable) begin
			if (!st_reg.pready) begin
				st_next.pready = 1'b1;
				st_next.prdata = pwrite ? 32'h0000_0000 : rd;
				st_next.pslverr = (idx > 6'(`PMEG_IX(`PMEG_OFS_STATUS)));
			end else if (pwrite && idx < 6'(`PMEG_NREG)) begin
				// Writes land on the completing edge only.
				st_next.file[idx[4:0]] = (idx == 6'd0) ?
					(pwdata[15:0] & `PMEG_CTRL_MASK) : pwdata[15:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.file[`PMEG_IX(`PMEG_OFS_LIMIT)] <= `PMEG_RST_LIMIT;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata  = st_reg.prdata;
	assign pready  = st_reg.pready;
	assign pslverr = st_reg.pslverr;

	assign cfgIf.cfg = '{
		mode:          pmeg_pkg::pmeg_mode_e'(st_reg.file[0][`PMEG_CTRL_MODE]),
		phaseFromDuty: st_reg.file[0][`PMEG_CTRL_PSRC],
		enable:        st_reg.file[0][`PMEG_CTRL_EN],
		limit:         st_reg.file[`PMEG_IX(`PMEG_OFS_LIMIT)],
		ev1:           st_reg.file[`PMEG_IX(`PMEG_OFS_EV1)],
		ev2:           st_reg.file[`PMEG_IX(`PMEG_OFS_EV2)],
		ev3:           st_reg.file[`PMEG_IX(`PMEG_OFS_EV3)],
		ev4:           st_reg.file[`PMEG_IX(`PMEG_OFS_EV4)],
		cadjA:         st_reg.file[`PMEG_IX(`PMEG_OFS_CADJA)],
		cadjB:         st_reg.file[`PMEG_IX(`PMEG_OFS_CADJB)],
		adapt:         st_reg.file[`PMEG_IX(`PMEG_OFS_ADAPT)],
		phase:         st_reg.file[`PMEG_IX(`PMEG_OFS_PHASE)],
		samp1:         st_reg.file[`PMEG_IX(`PMEG_OFS_SAMP1)],
		samp2:         st_reg.file[`PMEG_IX(`PMEG_OFS_SAMP2)],
		blkABeg:       st_reg.file[`PMEG_IX(`PMEG_OFS_BLKAB)],
		blkAEnd:       st_reg.file[`PMEG_IX(`PMEG_OFS_BLKAE)],
		blkBBeg:       st_reg.file[`PMEG_IX(`PMEG_OFS_BLKBB)],
		blkBEnd:       st_reg.file[`PMEG_IX(`PMEG_OFS_BLKBE)],
		dead1:         st_reg.file[`PMEG_IX(`PMEG_OFS_DEAD1)],
		dead2:         st_reg.file[`PMEG_IX(`PMEG_OFS_DEAD2)]
	};

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	apb_wait_one_a: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("APB access not answered after one wait state");
endmodule

// ===== hdl/pmeg_edge_calc.sv
// Computes this period's edge and trigger targets for the selected mode.
// Purely combinational; the core registers everything it produces.
`timescale 1ns/10ps
`include "pmeg_defines.svh"

module pmeg_edge_calc (
	// Configuration
	pmeg_cfg_if.view  cfgIf,
	// Mode, limit and duty in force, targets out
	pmeg_edge_if.calc edgeIf
);
	typedef pmeg_pkg::pmeg_wide_t wide_t;

	function automatic wide_t u(input pmeg_pkg::pmeg_cnt_t v);
		return wide_t'({2'b00, v});
	endfunction

	function automatic wide_t s(input pmeg_pkg::pmeg_cnt_t v);
		return wide_t'({{2{v[`PMEG_W-1]}}, v});
	endfunction

	// Out-of-range targets pin to the nearest end so the edge still fires.
	function automatic pmeg_pkg::pmeg_cnt_t clp(input wide_t v, input wide_t l);
		if (v < 0)
			return '0;
		else if (v > l)
			return l[`PMEG_W-1:0];
		else
			return v[`PMEG_W-1:0];
	endfunction

	wide_t d;
	wide_t l;
	wide_t aR;
	wide_t aF;
	wide_t bR;
	wide_t bF;
	wide_t tA;
	wide_t tB;
	wide_t on;
	wide_t bW;

	always_comb begin
		d  = u(edgeIf.duty);
		l  = u(edgeIf.lim);
		on = d - ((u(cfgIf.cfg.dead1) + u(cfgIf.cfg.dead2)) >>> 1);
		bW = d + s(cfgIf.cfg.cadjB);
		aR = '0;
		aF = '0;
		bR = '0;
		bF = '0;
		tA = '0;
		tB = '0;
		edgeIf.tgt.aEn = 1'b1;
		edgeIf.tgt.trigEn = 1'b1;
		edgeIf.tgt.bFull = 1'b0;
		case (edgeIf.mode)
			pmeg_pkg::MODE_MULTI: begin
				aR = u(cfgIf.cfg.ev1);
				aF = aR + d + s(cfgIf.cfg.cadjA);
				tA = aR + d + s(cfgIf.cfg.adapt);
				tB = aR + (d >>> 1) + s(cfgIf.cfg.adapt);
				bR = u(cfgIf.cfg.ev3);
				bF = bR + bW;
				edgeIf.tgt.bFull = (bW > l);
				if (bF > l)
					bF = bF - l - 1;
			end
			pmeg_pkg::MODE_RESONANT: begin
				aR = u(cfgIf.cfg.ev1);
				aF = aR + on;
				bR = aR + d;
				bF = bR + on;
				tA = aF + s(cfgIf.cfg.adapt);
				tB = aR + (on >>> 1) + s(cfgIf.cfg.adapt);
			end
			pmeg_pkg::MODE_TRIANGLE: begin
				edgeIf.tgt.aEn = 1'b0;
				edgeIf.tgt.trigEn = 1'b0;
				bR = ((l + 1) >>> 1) - (d >>> 1) + s(cfgIf.cfg.cadjA);
				bF = ((l + 1) >>> 1) + (d >>> 1) + s(cfgIf.cfg.cadjB);
			end
			pmeg_pkg::MODE_LEADING: begin
				aF = u(cfgIf.cfg.ev1);
				aR = aF - d + s(cfgIf.cfg.cadjA);
				tA = aF - d + s(cfgIf.cfg.adapt);
				tB = aF - (d >>> 1) + s(cfgIf.cfg.adapt);
				bR = u(cfgIf.cfg.ev4);
				bF = aR - (u(cfgIf.cfg.ev2) - u(cfgIf.cfg.ev3));
			end
			default: begin
				edgeIf.tgt.aEn = 1'b0;
				edgeIf.tgt.trigEn = 1'b0;
			end
		endcase
		edgeIf.tgt.aRise = clp(aR, l);
		edgeIf.tgt.aFall = clp(aF, l);
		edgeIf.tgt.bRise = clp(bR, l);
		edgeIf.tgt.bFall = clp(bF, l);
		edgeIf.tgt.trigA = clp(tA, l);
		edgeIf.tgt.trigB = clp(tB, l);
	end
endmodule

// ===== hdl/pmeg_top.sv
// Edge generator of one pulse channel: period counter, outputs A and B,
// adaptive and fixed sample triggers, blanking windows and phase trigger.
// Assumes the loop filter drives duty and period synchronous to ref_clk.
//
// Behaviour
// - Phase trigger uses fixed phase register or filter duty, selected by config.
// - Multi mode drives two equal-width phases, offset, own cycle adjusts.
// - Multi: A rises at event 1, falls at event 1 + duty + adjust A.
// - Multi: B rises at event 3, falls at event 3 + duty + adjust B.
// - Multi: adaptive triggers at event 1 + duty, or + duty/2, plus offset.
// - Multi: events 2 and 4 steer no edge.
// - Multi: B may wrap the period boundary keeping width; A never does.
// - Sample triggers and blanking windows follow only their own registers.
// - Resonant: A and B equal width, dead times fixed as period varies.
// - Resonant: period comes from the filter period output.
// - Resonant: on-time is duty minus average of both dead times.
// - Resonant: only A's rising edge stays fixed in the period.
// - Triangular: A idle, no adaptive triggers, only B active and centred.
// - Triangular: B edges at half period minus/plus half duty plus adjusts.
// - Leading: A falls at event 1, rises at event 1 - duty + adjust A.
// - Leading: B rises at event 4, falls ahead of A by event 2 - event 3.
// - Leading: adaptive triggers at event 1 - duty, or - duty/2, plus offset.
// - Period counter counts 0 up to the period limit, then restarts.
// - Each transition happens in the cycle the counter equals its target.
`timescale 1ns/10ps
`include "pmeg_defines.svh"

module pmeg_top (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Loop filter
	input  wire logic [15:0] filterDuty,
	input  wire logic [15:0] filterPeriod,
	// Gate drive outputs
	output logic             firstOutput,
	output logic             secondOutput,
	// Triggers and windows
	output logic             adaptTrigA,
	output logic             adaptTrigB,
	output logic             phaseTrig,
	output logic             sampleTrig1,
	output logic             sampleTrig2,
	output logic             blankA,
	output logic             blankB
);
	pmeg_cfg_if  cfgIf ();
	pmeg_edge_if edgeIf ();

	pmeg_pkg::pmeg_top_s  st_reg;
	pmeg_pkg::pmeg_top_s  st_next;
	pmeg_pkg::pmeg_cnt_t  nextCnt;
	pmeg_pkg::pmeg_cnt_t  phaseVal;
	pmeg_pkg::pmeg_cnt_t  newLim;
	logic                 wrap;

	pmeg_apb_regs u_regs (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.cfgIf   (cfgIf.regs)
	);

	pmeg_edge_calc u_calc (
		.cfgIf  (cfgIf.view),
		.edgeIf (edgeIf.calc)
	);

	// A stopped channel sits at a boundary so new settings apply at once.
	assign wrap = !cfgIf.cfg.enable || (st_reg.cnt == st_reg.lim);

	assign newLim = (cfgIf.cfg.mode == pmeg_pkg::MODE_RESONANT) ?
		filterPeriod : cfgIf.cfg.limit;

	// Targets are worked out for the mode and limit of the coming cycle,
	// so the first count of a new period already obeys the new mode.
	assign edgeIf.mode = wrap ? cfgIf.cfg.mode : st_reg.mode;
	assign edgeIf.lim  = wrap ? newLim : st_reg.lim;
	assign edgeIf.duty = filterDuty;

	assign phaseVal = cfgIf.cfg.phaseFromDuty ?
		filterDuty : cfgIf.cfg.phase;

	assign nextCnt = wrap ? '0 : st_reg.cnt + 1'b1;

	always_comb begin
		st_next = st_reg;
		st_next.cnt = nextCnt;
		st_next.mode = edgeIf.mode;
		st_next.lim = edgeIf.lim;
		if (!cfgIf.cfg.enable) begin
			st_next.outA = 1'b0;
			st_next.outB = 1'b0;
			st_next.trigA = 1'b0;
			st_next.trigB = 1'b0;
			st_next.phase = 1'b0;
			st_next.samp1 = 1'b0;
			st_next.samp2 = 1'b0;
			st_next.blkA = 1'b0;
			st_next.blkB = 1'b0;
		end else begin
			// A clear on the same count as a set wins: zero width stays low.
			if (!edgeIf.tgt.aEn)
				st_next.outA = 1'b0;
			else if (nextCnt == edgeIf.tgt.aFall)
				st_next.outA = 1'b0;
			else if (nextCnt == edgeIf.tgt.aRise)
				st_next.outA = 1'b1;
			// Outputs are not forced low at the boundary, so a wrapped B
			// pulse carries on into the next period with its full width.
			if (edgeIf.tgt.bFull)
				st_next.outB = 1'b1;
			else if (nextCnt == edgeIf.tgt.bFall)
				st_next.outB = 1'b0;
			else if (nextCnt == edgeIf.tgt.bRise)
				st_next.outB = 1'b1;
			st_next.trigA = edgeIf.tgt.trigEn &&
				(nextCnt == edgeIf.tgt.trigA);
			st_next.trigB = edgeIf.tgt.trigEn &&
				(nextCnt == edgeIf.tgt.trigB);
			st_next.phase = (nextCnt == phaseVal);
			st_next.samp1 = (nextCnt == cfgIf.cfg.samp1);
			st_next.samp2 = (nextCnt == cfgIf.cfg.samp2);
			if (nextCnt == cfgIf.cfg.blkAEnd)
				st_next.blkA = 1'b0;
			else if (nextCnt == cfgIf.cfg.blkABeg)
				st_next.blkA = 1'b1;
			if (nextCnt == cfgIf.cfg.blkBEnd)
				st_next.blkB = 1'b0;
			else if (nextCnt == cfgIf.cfg.blkBBeg)
				st_next.blkB = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.lim <= `PMEG_RST_LIMIT;
		end else begin
			st_reg <= st_next;
		end
	end

	assign cfgIf.stat.cnt  = st_reg.cnt;
	assign cfgIf.stat.mode = st_reg.mode;
	assign cfgIf.stat.outA = st_reg.outA;
	assign cfgIf.stat.outB = st_reg.outB;

	assign firstOutput  = st_reg.outA;
	assign secondOutput = st_reg.outB;
	assign adaptTrigA   = st_reg.trigA;
	assign adaptTrigB   = st_reg.trigB;
	assign phaseTrig    = st_reg.phase;
	assign sampleTrig1  = st_reg.samp1;
	assign sampleTrig2  = st_reg.samp2;
	assign blankA       = st_reg.blkA;
	assign blankB       = st_reg.blkB;

	// Checks on the counter, the edges and the boundary behaviour.
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_period_end;
		cfgIf.cfg.enable && st_reg.cnt == st_reg.lim;
	endsequence

	sequence s_restart;
		st_reg.cnt == '0;
	endsequence

	cnt_wrap_a: assert property (
		s_period_end |=> s_restart ##1 (st_reg.cnt == 1 || wrap))
		else $error("Period counter did not restart from zero");

	cnt_step_a: assert property (
		cfgIf.cfg.enable && !wrap |=> st_reg.cnt == $past(st_reg.cnt) + 1'b1)
		else $error("Period counter did not step by one");

	a_rise_pos_a: assert property (
		$rose(st_reg.outA) |-> st_reg.cnt == $past(edgeIf.tgt.aRise))
		else $error("Output A rose away from its target");

	b_rise_pos_a: assert property (
		$rose(st_reg.outB) && !$past(edgeIf.tgt.bFull) |->
		st_reg.cnt == $past(edgeIf.tgt.bRise))
		else $error("Output B rose away from its target");

	tri_quiet_a: assert property (
		cfgIf.cfg.enable && edgeIf.mode == pmeg_pkg::MODE_TRIANGLE |=>
		!st_reg.outA && !st_reg.trigA && !st_reg.trigB)
		else $error("Triangular mode produced A or adaptive trigger");

	mode_hold_a: assert property (
		!wrap |=> $stable(st_reg.mode) && $stable(st_reg.lim))
		else $error("Mode or limit changed inside a period");

	phase_pos_a: assert property (
		st_reg.phase |-> st_reg.cnt == $past(phaseVal))
		else $error("Phase trigger away from its selected value");

	samp_pos_a: assert property (
		st_reg.samp1 |-> st_reg.cnt == $past(cfgIf.cfg.samp1))
		else $error("Sample trigger 1 away from its register");

	tgt_clamp_a: assert property (
		edgeIf.tgt.aFall <= edgeIf.lim && edgeIf.tgt.bRise <= edgeIf.lim)
		else $error("Edge target outside the counter range");

	multi_a_end_a: assert property (
		edgeIf.mode == pmeg_pkg::MODE_MULTI && edgeIf.tgt.aRise < edgeIf.lim
		|-> edgeIf.tgt.aFall >= edgeIf.tgt.aRise ||
		edgeIf.tgt.aFall == '0)
		else $error("Output A crosses the period end in multi mode");
endmodule

// ===== dv/pmeg_filter_model.sv
// Loop filter stand-in that feeds duty and period to the edge generator.
// Assumes the bench requests a duty synchronous to ref_clk.
`timescale 1ns/10ps

module pmeg_filter_model (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Duty asked for by the bench
	input  wire logic [15:0] dutyReq,
	// Filter outputs
	output logic      [15:0] filterDuty,
	output logic      [15:0] filterPeriod
);
	// The period is kept at twice the duty, as a resonant set-up needs.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			filterDuty   <= 16'h0000;
			filterPeriod <= 16'h0000;
		end else begin
			filterDuty   <= dutyReq;
			filterPeriod <= {dutyReq[14:0], 1'b0};
		end
	end
endmodule

// ===== dv/tb_pwm_edge_mode_generator.sv
// Self-checking bench for the pulse-channel edge generator.
// Assumes pmeg_pkg, the interfaces and the design files are compiled first.
`timescale 1ns/10ps
`include "pmeg_defines.svh"

module tb_pwm_edge_mode_generator;
	logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] dutyReq, filterDuty, filterPeriod;
	logic        firstOutput, secondOutput, adaptTrigA, adaptTrigB;
	logic        phaseTrig, sampleTrig1, sampleTrig2, blankA, blankB;
	logic [7:0]  seen;
	int          miscompares, checkCount, d, psrc;
	int          r[18];

	assign seen = {firstOutput, secondOutput, adaptTrigA, adaptTrigB,
		phaseTrig, sampleTrig2, blankA, blankB};

	pmeg_top dut_u (
		.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .filterDuty(filterDuty),
		.filterPeriod(filterPeriod), .firstOutput(firstOutput),
		.secondOutput(secondOutput), .adaptTrigA(adaptTrigA),
		.adaptTrigB(adaptTrigB), .phaseTrig(phaseTrig),
		.sampleTrig1(sampleTrig1), .sampleTrig2(sampleTrig2),
		.blankA(blankA), .blankB(blankB)
	);

	pmeg_filter_model filter_u (
		.ref_clk(ref_clk), .rst_n(rst_n), .dutyReq(dutyReq),
		.filterDuty(filterDuty), .filterPeriod(filterPeriod)
	);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checkCount++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// The master waits up to 50 cycles for pready, then counts a mismatch.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		int n = 0;
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic inw(int k, int a, int b);
		return k >= a && k < b;
	endfunction

	// Expected outputs at count k; r[] holds the words as written.
	function automatic logic [7:0] model(int m, int k, int L);
		int  on, bf, h;
		logic a = 1'b0;
		logic b = 1'b0;
		logic ta = 1'b0;
		logic tb = 1'b0;
		case (m)
			0: begin
				a = inw(k, r[2], r[2] + d + r[6]);
				bf = r[4] + d + r[7];
				b = (bf > L) ? (k >= r[4] || k < bf - L - 1) : inw(k, r[4], bf);
				ta = k == r[2] + d + r[8];
				tb = k == r[2] + d / 2 + r[8];
			end
			1: begin
				on = d - (r[16] + r[17]) / 2;
				a = inw(k, r[2], r[2] + on);
				b = inw(k, r[2] + d, r[2] + d + on);
				ta = k == r[2] + on + r[8];
				tb = k == r[2] + on / 2 + r[8];
			end
			2: begin
				h = (L + 1) / 2;
				b = inw(k, h - d / 2 + r[6], h + d / 2 + r[7]);
			end
			default: begin
				a = inw(k, r[2] - d + r[6], r[2]);
				b = inw(k, r[5], r[2] - d + r[6] - (r[3] - r[4]));
				ta = k == r[2] - d + r[8];
				tb = k == r[2] - d / 2 + r[8];
			end
		endcase
		return {a, b, ta, tb, k == (psrc != 0 ? d : r[9]), k == r[11],
			inw(k, r[12], r[13]), inw(k, r[14], r[15])};
	endfunction

	task automatic run_mode(input int m);
		int L = (m == 1) ? 2 * d : r[1];
		int n;
		logic [7:0] e;
		for (int i = 1; i < 18; i++) begin
			apb(1'b1, 8'(i * 4), 32'(r[i]));
		end
		dutyReq <= 16'(d);
		apb(1'b1, `PMEG_OFS_CTRL, 32'(m + psrc * 4 + 8));
		// Two period starts pass so the new mode and limit are in force.
		repeat (2) begin
			n = 0;
			do begin
				@(negedge ref_clk);
				n++;
			end while (sampleTrig1 !== 1'b1 && n < 300);
			if (n >= 300) begin
				miscompares++;
			end
		end
		for (int k = 0; k <= L; k++) begin
			e = model(m, k, L);
			case (m)
				0: chk("multi", 32'(e[7:4]), 32'(seen[7:4]));
				1: chk("resonant", 32'(e[7:4]), 32'(seen[7:4]));
				2: chk("triangular", 32'(e[7:4]), 32'(seen[7:4]));
				default: chk("leading", 32'(e[7:4]), 32'(seen[7:4]));
			endcase
			chk("fixed", 32'(e[3:0]), 32'(seen[3:0]));
			@(negedge ref_clk);
		end
		chk("restart", 32'h0000_0001, 32'(sampleTrig1));
		$display("Mode %0d test done", m);
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		end_of_test;
	end

	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		dutyReq = 16'h0000;
		miscompares = 0;
		checkCount = 0;
		void'($urandom(32'h0000_9439));
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		apb(1'b0, `PMEG_OFS_LIMIT, 32'h0000_0000);
		chk("limit reset", 32'h0000_03E7, rd);
		apb(1'b1, `PMEG_OFS_CTRL, 32'h0000_00F0);
		apb(1'b0, `PMEG_OFS_CTRL, 32'h0000_0000);
		chk("control mask", 32'h0000_0000, rd);
		apb(1'b0, 8'h4C, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, 32'(err));
		chk("unmapped data", 32'h0000_0000, rd);
		$display("Register test done");
		r = '{0, 39, 0, 0, 0, 0, 0, 0, 1, 7, 0, 11, 1, 4, 25, 28, 2, 4};
		for (int m = 0; m < 4; m++) begin
			psrc = 0;
			case (m)
				0: begin
					r[2:7] = '{2, $urandom % 40, 30, $urandom % 40, 3, 2};
					d = 8 + $urandom % 5;
				end
				1: begin
					r[2] = 1;
					d = 16;
					psrc = 1;
				end
				2: begin
					r[6:7] = '{1, 2};
					d = 10;
				end
				default: begin
					r[2:7] = '{30, 8, 5, 3, 2, 0};
					d = 10;
				end
			endcase
			run_mode(m);
		end
		end_of_test;
	end
endmodule
